// ### pkc_consts.svh
// Offsets, field positions, reset values and timing for the power key bank
`ifndef PKC_CONSTS_SVH
`define PKC_CONSTS_SVH
`define PKC_CLK_HZ 40000000
`define PKC_TICK_US 1000
`define PKC_TICK_CYC (`PKC_CLK_HZ / 1000000 * `PKC_TICK_US)
`define PKC_ADDR_W 12
`define PKC_IDX_SD_CTRL 12'h10e
`define PKC_IDX_IF_KEY 12'h10f
`define PKC_IDX_PULL_LO 12'h110
`define PKC_IDX_PULL_HI 12'h111
`define PKC_IDX_PIN_DIR 12'h120
`define PKC_IDX_PIN_TYPE 12'h121
`define PKC_IDX_STATUS 12'h122
`define PKC_RST_IF_KEY 8'h00
`define PKC_RST_SD_CTRL 8'h00
`define PKC_RST_PULL 8'h00
`define PKC_RST_PIN 16'h0000
`define PKC_BIT_IF_AUTO_RST 7
`define PKC_BIT_SCL_TO_EN 6
`define PKC_FLD_RST_DUR_HI 5
`define PKC_FLD_RST_DUR_LO 4
`define PKC_FLD_SHUT_HI 3
`define PKC_FLD_SHUT_LO 2
`define PKC_FLD_KEY_HI 1
`define PKC_FLD_KEY_LO 0
`define PKC_BIT_SD_STYLE 4
`define PKC_BIT_DUAL_SD_EN 3
`define PKC_BIT_KEY_SD_EN 2
`define PKC_SCL_TO_MS 14'h0013
`define PKC_RST_MS_0 14'h0014
`define PKC_RST_MS_1 14'h0064
`define PKC_RST_MS_2 14'h01f4
`define PKC_RST_MS_3 14'h03e8
`define PKC_KEY_MS_0 14'h03e8
`define PKC_KEY_MS_1 14'h05dc
`define PKC_KEY_MS_2 14'h07d0
`define PKC_KEY_MS_3 14'h1b58
`define PKC_SHUT_MS_0 14'h0000
`define PKC_SHUT_MS_1 14'h0fa0
`define PKC_SHUT_MS_2 14'h1388
`define PKC_SHUT_MS_3 14'h1770
`define PKC_MS_MAX 14'h3fff
`endif

// ### pkc_far.sv
// Far-side model: power key, shutdown pin, two-wire clock and pins
`timescale 1ns/1ps
`default_nettype none
module pkc_far (
    input wire logic clk_i,
    input wire logic key_c_i,
    input wire logic pair_c_i,
    input wire logic sd_c_i,
    input wire logic scl_c_i,
    output logic key_n_o = 1'b1,
    output logic sd_n_o = 1'b1,
    output logic scl_o = 1'b1,
    output logic [15:0] pin_o = 16'h0000
);
    // A stopped clock line is pulled back up, so it idles high
    always_ff @(posedge clk_i) begin
        key_n_o <= !key_c_i;
        sd_n_o <= !sd_c_i;
        scl_o <= scl_c_i ? !scl_o : 1'b1;
        pin_o <= {pair_c_i, pair_c_i, 14'h0000};
    end
endmodule
`default_nettype wire

// ### pkc_pkg.sv
// Types for the power key and pull configuration bank
package pkc_pkg;
    typedef logic [13:0] pkc_ms_t;
    typedef enum logic [0:0] {
        PKC_ST_RESET = 1'b0,
        PKC_ST_ACTIVE = 1'b1
    } pkc_state_t;
endpackage

// ### pkc_top.sv
// Power key timing, interface reset and pin pull configuration bank
`include "pkc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module pkc_top import pkc_pkg::*; #(
    parameter int unsigned TICK_CYC = `PKC_TICK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [11:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic power_key_n_i,
    input wire logic shutdown_pin_n_i,
    input wire logic serial_clk_i,
    input wire logic [15:0] pin_input_i,
    output logic if_reset_o,
    output logic serial_if_reset_o,
    output logic power_key_lock_o,
    output logic key_lock_event_o,
    output logic shutdown_req_o,
    output logic por_req_o,
    output logic reset_state_o,
    output logic power_up_start_o,
    output logic [15:0] pull_down_en_o,
    output logic [15:0] pull_up_en_o,
    output logic [15:0] pull_up_rail_o
);

    function automatic pkc_ms_t key_ms(input logic [1:0] code);
        unique case (code)
            2'h0: key_ms = `PKC_KEY_MS_0;
            2'h1: key_ms = `PKC_KEY_MS_1;
            2'h2: key_ms = `PKC_KEY_MS_2;
            2'h3: key_ms = `PKC_KEY_MS_3;
        endcase
    endfunction

    function automatic pkc_ms_t shut_ms(input logic [3:0] codes);
        pkc_ms_t extra;
        unique case (codes[3:2])
            2'h0: extra = `PKC_SHUT_MS_0;
            2'h1: extra = `PKC_SHUT_MS_1;
            2'h2: extra = `PKC_SHUT_MS_2;
            2'h3: extra = `PKC_SHUT_MS_3;
        endcase
        shut_ms = key_ms(codes[1:0]) + extra;
    endfunction

    function automatic pkc_ms_t ms_step(input logic held, input logic tick,
                                        input pkc_ms_t cnt);
        if (!held) begin
            ms_step = '0;
        end else if (tick && cnt != `PKC_MS_MAX) begin
            ms_step = cnt + 14'h0001;
        end else begin
            ms_step = cnt;
        end
    endfunction

    // Registers and bus state
    logic [7:0] if_key_reg, if_key_next;
    logic [7:0] sd_ctrl_reg, sd_ctrl_next;
    logic [15:0] pull_reg, pull_next;
    logic [15:0] pin_dir_reg, pin_dir_next;
    logic [15:0] pin_type_reg, pin_type_next;
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    // Engine state
    logic [15:0] tick_cnt_reg, tick_cnt_next;
    logic tick_reg, tick_next;
    logic scl_prev_reg, scl_prev_next;
    pkc_ms_t scl_idle_reg, scl_idle_next;
    pkc_ms_t key_cnt_reg, key_cnt_next;
    pkc_ms_t pair_cnt_reg, pair_cnt_next;
    pkc_ms_t rst_cnt_reg, rst_cnt_next;
    pkc_state_t state_reg, state_next;
    logic if_rst_reg, if_rst_next;
    logic scl_rst_reg, scl_rst_next;
    logic lock_reg, lock_next;
    logic lock_ev_reg, lock_ev_next;
    logic sd_reg, sd_next;
    logic por_reg, por_next;
    logic pwr_up_reg, pwr_up_next;
    logic [15:0] pd_reg, pd_next;
    logic [15:0] pu_reg, pu_next;

    logic key_held, pair_held, req;
    pkc_ms_t lock_thr, sd_thr, rst_thr;

    always_comb begin
        req = avs_read_i | avs_write_i;
        if_key_next = if_key_reg;
        sd_ctrl_next = sd_ctrl_reg;
        pull_next = pull_reg;
        pin_dir_next = pin_dir_reg;
        pin_type_next = pin_type_reg;
        rdata_next = rdata_reg;
        // One wait cycle: answer always comes on the second edge
        wait_next = 1'b1;
        if (req && wait_reg) begin
            wait_next = 1'b0;
            rdata_next = '0;
            if (avs_address_i[1:0] == 2'h0) begin
                unique case ({2'b00, avs_address_i[11:2]})
                    `PKC_IDX_SD_CTRL: rdata_next[7:0] = sd_ctrl_reg;
                    `PKC_IDX_IF_KEY: rdata_next[7:0] = if_key_reg;
                    `PKC_IDX_PULL_LO: rdata_next[7:0] = pull_reg[7:0];
                    `PKC_IDX_PULL_HI: rdata_next[7:0] = pull_reg[15:8];
                    `PKC_IDX_PIN_DIR: rdata_next[15:0] = pin_dir_reg;
                    `PKC_IDX_PIN_TYPE: rdata_next[15:0] = pin_type_reg;
                    `PKC_IDX_STATUS: rdata_next[3:0] = {pair_held, key_held,
                        lock_reg, state_reg == PKC_ST_RESET};
                    default: rdata_next = '0;
                endcase
            end
        end
        // Write lands on the edge that sees waitrequest low
        if (avs_write_i && !wait_reg && avs_address_i[1:0] == 2'h0) begin
            unique case ({2'b00, avs_address_i[11:2]})
                `PKC_IDX_SD_CTRL:
                    if (avs_byteenable_i[0])
                        sd_ctrl_next = avs_writedata_i[7:0];
                `PKC_IDX_IF_KEY:
                    if (avs_byteenable_i[0])
                        if_key_next = avs_writedata_i[7:0];
                // low pins at first byte register, high at second
                `PKC_IDX_PULL_LO:
                    if (avs_byteenable_i[0])
                        pull_next[7:0] = avs_writedata_i[7:0];
                `PKC_IDX_PULL_HI:
                    if (avs_byteenable_i[0])
                        pull_next[15:8] = avs_writedata_i[7:0];
                `PKC_IDX_PIN_DIR: begin
                    if (avs_byteenable_i[0])
                        pin_dir_next[7:0] = avs_writedata_i[7:0];
                    if (avs_byteenable_i[1])
                        pin_dir_next[15:8] = avs_writedata_i[15:8];
                end
                `PKC_IDX_PIN_TYPE: begin
                    if (avs_byteenable_i[0])
                        pin_type_next[7:0] = avs_writedata_i[7:0];
                    if (avs_byteenable_i[1])
                        pin_type_next[15:8] = avs_writedata_i[15:8];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            if_key_reg <= `PKC_RST_IF_KEY;
            sd_ctrl_reg <= `PKC_RST_SD_CTRL;
            pull_reg <= {`PKC_RST_PULL, `PKC_RST_PULL};
            pin_dir_reg <= `PKC_RST_PIN;
            pin_type_reg <= `PKC_RST_PIN;
            wait_reg <= 1'b1;
            rdata_reg <= '0;
        end else begin
            if_key_reg <= if_key_next;
            sd_ctrl_reg <= sd_ctrl_next;
            pull_reg <= pull_next;
            pin_dir_reg <= pin_dir_next;
            pin_type_reg <= pin_type_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    always_comb begin
        key_held = ~power_key_n_i;
        pair_held = pin_input_i[14] & pin_input_i[15];
        lock_thr = key_ms(if_key_reg[`PKC_FLD_KEY_HI:`PKC_FLD_KEY_LO]);
        sd_thr = shut_ms(if_key_reg[`PKC_FLD_SHUT_HI:`PKC_FLD_KEY_LO]);
        unique case (if_key_reg[`PKC_FLD_RST_DUR_HI:`PKC_FLD_RST_DUR_LO])
            2'h0: rst_thr = `PKC_RST_MS_0;
            2'h1: rst_thr = `PKC_RST_MS_1;
            2'h2: rst_thr = `PKC_RST_MS_2;
            2'h3: rst_thr = `PKC_RST_MS_3;
        endcase
        // Millisecond tick; all long times are counted in ticks
        tick_next = (tick_cnt_reg == 16'(TICK_CYC - 1));
        tick_cnt_next = tick_next ? 16'h0000 : tick_cnt_reg + 16'h0001;
        if_rst_next = if_key_reg[`PKC_BIT_IF_AUTO_RST] & ~shutdown_pin_n_i;
        // idle clock timeout, one pulse per stall
        scl_prev_next = serial_clk_i;
        scl_idle_next = ms_step(serial_clk_i == scl_prev_reg, tick_reg,
                                scl_idle_reg);
        scl_rst_next = if_key_reg[`PKC_BIT_SCL_TO_EN] &&
            scl_idle_next == `PKC_SCL_TO_MS + 14'h0001 &&
            scl_idle_reg == `PKC_SCL_TO_MS;
        // timers run only while held, equality edge fires once
        key_cnt_next = ms_step(key_held, tick_reg, key_cnt_reg);
        pair_cnt_next = ms_step(pair_held, tick_reg, pair_cnt_reg);
        lock_ev_next = key_cnt_next == lock_thr && key_cnt_reg != lock_thr;
        lock_next = key_held & (lock_reg | lock_ev_next);
        sd_next = 1'b0;
        por_next = 1'b0;
        pwr_up_next = 1'b0;
        state_next = state_reg;
        rst_cnt_next = rst_cnt_reg;
        unique case (state_reg)
            PKC_ST_RESET: begin
                rst_cnt_next = ms_step(1'b1, tick_reg, rst_cnt_reg);
                if (rst_cnt_next >= rst_thr) begin
                    state_next = PKC_ST_ACTIVE;
                    pwr_up_next = 1'b1;
                end
            end
            PKC_ST_ACTIVE: begin
                // shutdown at lock delay plus extra
                // key path gated by its enable
                // pin pair path gated by its enable
                if ((sd_ctrl_reg[`PKC_BIT_KEY_SD_EN] &&
                     key_cnt_next == sd_thr && key_cnt_reg != sd_thr) ||
                    (sd_ctrl_reg[`PKC_BIT_DUAL_SD_EN] &&
                     pair_cnt_next == sd_thr && pair_cnt_reg != sd_thr)) begin
                    if (sd_ctrl_reg[`PKC_BIT_SD_STYLE]) begin
                        // instant reset path reenters timed reset
                        por_next = 1'b1;
                        state_next = PKC_ST_RESET;
                        rst_cnt_next = '0;
                    end else begin
                        sd_next = 1'b1;
                    end
                end
            end
        endcase
        // bit clear leaves both pulls off
        // pull-down for inputs, pull-up for every output whatever its pin type
        pd_next = pull_reg & ~pin_dir_reg;
        pu_next = pull_reg & pin_dir_reg;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b0;
            scl_prev_reg <= 1'b0;
            scl_idle_reg <= '0;
            key_cnt_reg <= '0;
            pair_cnt_reg <= '0;
            rst_cnt_reg <= '0;
            state_reg <= PKC_ST_RESET;
            if_rst_reg <= 1'b0;
            scl_rst_reg <= 1'b0;
            lock_reg <= 1'b0;
            lock_ev_reg <= 1'b0;
            sd_reg <= 1'b0;
            por_reg <= 1'b0;
            pwr_up_reg <= 1'b0;
            pd_reg <= '0;
            pu_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
            scl_prev_reg <= scl_prev_next;
            scl_idle_reg <= scl_idle_next;
            key_cnt_reg <= key_cnt_next;
            pair_cnt_reg <= pair_cnt_next;
            rst_cnt_reg <= rst_cnt_next;
            state_reg <= state_next;
            if_rst_reg <= if_rst_next;
            scl_rst_reg <= scl_rst_next;
            lock_reg <= lock_next;
            lock_ev_reg <= lock_ev_next;
            sd_reg <= sd_next;
            por_reg <= por_next;
            pwr_up_reg <= pwr_up_next;
            pd_reg <= pd_next;
            pu_reg <= pu_next;
        end
    end

    assign avs_readdata_o = rdata_reg;
    assign avs_waitrequest_o = wait_reg;
    assign if_reset_o = if_rst_reg;
    assign serial_if_reset_o = scl_rst_reg;
    assign power_key_lock_o = lock_reg;
    assign key_lock_event_o = lock_ev_reg;
    assign shutdown_req_o = sd_reg;
    assign por_req_o = por_reg;
    assign reset_state_o = (state_reg == PKC_ST_RESET);
    assign power_up_start_o = pwr_up_reg;
    assign pull_down_en_o = pd_reg;
    assign pull_up_en_o = pu_reg;
    // Rail choice passes straight through; the pad picks it only when pulled up
    assign pull_up_rail_o = pin_type_reg;

endmodule
`default_nettype wire

// ### pkc_top_asserts.sv
// Port checker for the power key and pull bank
`timescale 1ns/1ps
`default_nettype none
module pkc_top_asserts #(
    parameter int unsigned TICK_CYC = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic power_key_n_i,
    input wire logic shutdown_pin_n_i,
    input wire logic serial_clk_i,
    input wire logic if_reset_o,
    input wire logic serial_if_reset_o,
    input wire logic power_key_lock_o,
    input wire logic key_lock_event_o,
    input wire logic shutdown_req_o,
    input wire logic por_req_o,
    input wire logic reset_state_o,
    input wire logic power_up_start_o,
    input wire logic [15:0] pull_down_en_o,
    input wire logic [15:0] pull_up_en_o
);
    localparam int unsigned IDLE_MIN = 19 * TICK_CYC;
    localparam int unsigned KEY_MIN = 999 * TICK_CYC;
    int unsigned idle_cnt;
    int unsigned press_cnt;
    int unsigned rs_cnt;
    logic scl_q;
    // Counts lead the design's own, which sees inputs in the same cycle but steps only on its millisecond tick
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idle_cnt <= 0;
            press_cnt <= 0;
            rs_cnt <= 0;
            scl_q <= 1'b1;
        end else begin
            idle_cnt <= (serial_clk_i != scl_q) ? 0 : idle_cnt + 1;
            press_cnt <= power_key_n_i ? 0 : press_cnt + 1;
            rs_cnt <= reset_state_o ? rs_cnt + 1 : 0;
            scl_q <= serial_clk_i;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_held; reset_state_o [*8]; endsequence
    sequence s_left; !reset_state_o; endsequence
    property p_if_rst; if_reset_o |-> $past(!shutdown_pin_n_i); endproperty
    property p_sif;
        serial_if_reset_o |-> idle_cnt >= IDLE_MIN ##1 !serial_if_reset_o;
    endproperty
    property p_lock;
        key_lock_event_o |-> press_cnt >= KEY_MIN ##1 !key_lock_event_o;
    endproperty
    property p_rel; $rose(power_key_n_i) |-> ##[1:4] !power_key_lock_o;
    endproperty
    property p_sd; shutdown_req_o |-> $past(!reset_state_o); endproperty
    property p_por; por_req_o |=> s_held; endproperty
    property p_pu; power_up_start_o |-> rs_cnt >= IDLE_MIN ##1 s_left;
    endproperty
    property p_pull; (pull_down_en_o & pull_up_en_o) == 16'h0000; endproperty
    property p_bus; (avs_read_i || avs_write_i) && avs_waitrequest_o |=>
        !avs_waitrequest_o ##1 avs_waitrequest_o; endproperty
    a_if_rst: assert property (p_if_rst) else $error("if reset");
    a_sif: assert property (p_sif) else $error("serial reset");
    a_lock: assert property (p_lock) else $error("lock event");
    a_rel: assert property (p_rel) else $error("lock release");
    a_sd: assert property (p_sd) else $error("shutdown");
    a_por: assert property (p_por) else $error("por hold");
    a_pu: assert property (p_pu) else $error("power up");
    a_pull: assert property (p_pull) else $error("pull both");
    a_bus: assert property (p_bus) else $error("bus wait");
endmodule
bind pkc_top pkc_top_asserts #(.TICK_CYC(TICK_CYC)) chk_u (.clk_i, .rst_n_i,
    .avs_read_i, .avs_write_i, .avs_waitrequest_o, .power_key_n_i,
    .shutdown_pin_n_i, .serial_clk_i, .if_reset_o, .serial_if_reset_o,
    .power_key_lock_o, .key_lock_event_o, .shutdown_req_o, .por_req_o,
    .reset_state_o, .power_up_start_o, .pull_down_en_o, .pull_up_en_o);
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the power key and pull bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [11:0] addr = 12'h000;
    logic rd_r = 1'b0, wr_r = 1'b0, key_c = 1'b0, pair_c = 1'b0;
    logic sd_c = 1'b0, scl_c = 1'b1;
    logic [31:0] wdat = 32'h0, rdat, rd_d;
    logic key_n, sd_n, scl, wrq, ifr, sifr, lock, lev, sdr, por, rst_st, pu;
    logic [15:0] pin, pd, pu_en, rail;
    int err_count = 0, n_tests = 0, cyc = 0, t0 = 0, t_lock = 0, t_sd = 0;
    int t_por = 0, t_pu = 0, n_lock = 0, n_sd = 0, n_por = 0, n_sif = 0;
    always #12.5 clk_i = ~clk_i;
    pkc_far far_u (.clk_i(clk_i), .key_c_i(key_c), .pair_c_i(pair_c),
        .sd_c_i(sd_c), .scl_c_i(scl_c), .key_n_o(key_n), .sd_n_o(sd_n),
        .scl_o(scl), .pin_o(pin));
    pkc_top #(.TICK_CYC(4)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .avs_address_i(addr), .avs_read_i(rd_r), .avs_write_i(wr_r),
        .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wrq),
        .power_key_n_i(key_n), .shutdown_pin_n_i(sd_n), .serial_clk_i(scl),
        .pin_input_i(pin), .if_reset_o(ifr), .serial_if_reset_o(sifr),
        .power_key_lock_o(lock), .key_lock_event_o(lev),
        .shutdown_req_o(sdr), .por_req_o(por), .reset_state_o(rst_st),
        .power_up_start_o(pu), .pull_down_en_o(pd), .pull_up_en_o(pu_en),
        .pull_up_rail_o(rail));
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        n_sif <= n_sif + (sifr === 1'b1);
        n_sd <= n_sd + (sdr === 1'b1);
        n_por <= n_por + (por === 1'b1);
        n_lock <= n_lock + (lev === 1'b1);
        if (lev === 1'b1) t_lock <= cyc - t0;
        if (sdr === 1'b1) t_sd <= cyc - t0;
        if (por === 1'b1) t_por <= cyc;
        if (pu === 1'b1) t_pu <= cyc;
    end
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdat <= d;
        wr_r <= w;
        rd_r <= !w;
        do @(posedge clk_i); while (wrq !== 1'b0);
        rd_d = rdat;
        wr_r <= 1'b0;
        rd_r <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [11:0] a,
                       input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(nm, rd_d, e);
    endtask
    // Hold the key or the pin pair for n cycles, then let go
    task automatic press(input logic pair, input int n);
        @(posedge clk_i);
        key_c <= !pair;
        pair_c <= pair;
        t0 <= cyc;
        repeat (n) @(posedge clk_i);
        key_c <= 1'b0;
        pair_c <= 1'b0;
        repeat (20) @(posedge clk_i);
    endtask
    task automatic summarize;
        if (err_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge clk_i);
        err_count++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdc("timing", 12'h43c, 0);
        rdc("pull_lo", 12'h440, 0);
        rdc("pull_hi", 12'h444, 0);
        repeat (100) @(posedge clk_i);
        chk("pu_time", t_pu inside {[93:101]}, 1);
        wr(12'h400, 32'hff);
        rdc("unmapped", 12'h400, 0);
        wr(12'h480, 32'h0f0f);
        wr(12'h484, 32'h3c3c);
        wr(12'h440, 32'ha5);
        wr(12'h444, 32'h96);
        rdc("pull_hi", 12'h444, 32'h96);
        chk("pd", pd, 16'h96a5 & ~16'h0f0f);
        chk("pu", pu_en, 16'h96a5 & 16'h0f0f);
        chk("rail", rail, 16'h3c3c);
        wr(12'h440, 32'h00);
        rdc("pull_lo", 12'h440, 0);
        chk("pd", pd, 16'h9000);
        chk("pu", pu_en, 16'h0600);
        sd_c <= 1'b1;
        wr(12'h43c, 32'h80);
        repeat (3) @(posedge clk_i);
        chk("if_rst", ifr, 1);
        wr(12'h43c, 32'h00);
        repeat (3) @(posedge clk_i);
        chk("if_rst", ifr, 0);
        sd_c <= 1'b0;
        scl_c <= 1'b0;
        repeat (120) @(posedge clk_i);
        chk("sif", n_sif, 0);
        scl_c <= 1'b1;
        wr(12'h43c, 32'h40);
        repeat (120) @(posedge clk_i);
        chk("sif", n_sif, 0);
        scl_c <= 1'b0;
        repeat (100) @(posedge clk_i);
        chk("sif", n_sif, 1);
        scl_c <= 1'b1;
        wr(12'h43c, 32'h00);
        press(0, 4100);
        chk("t_lock", t_lock inside {[3990:4012]}, 1);
        chk("lock", lock, 0);
        chk("sd_off", n_sd, 0);
        wr(12'h438, 32'h04);
        press(0, 2000);
        chk("short", n_lock, 1);
        press(0, 4100);
        chk("sd_on", n_sd, 1);
        chk("once", n_lock, 2);
        press(1, 4100);
        chk("pair_off", n_sd, 1);
        wr(12'h438, 32'h08);
        press(1, 4100);
        chk("pair_on", n_sd, 2);
        wr(12'h438, 32'h04);
        wr(12'h43c, 32'h04);
        press(0, 20100);
        chk("t_sd", t_sd inside {[19990:20012]}, 1);
        wr(12'h438, 32'h14);
        wr(12'h43c, 32'h10);
        press(0, 4100);
        chk("por", n_por, 1);
        chk("rst_st", rst_st, 1);
        rdc("status", 12'h488, 32'h1);
        repeat (420) @(posedge clk_i);
        chk("rst_st", rst_st, 0);
        chk("t_rst", (t_pu - t_por) inside {[392:408]}, 1);
        summarize();
    end
endmodule
`default_nettype wire
